//--- rtl/cid_defs.svh
`ifndef CID_DEFS_SVH
`define CID_DEFS_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CID_CLK_HZ 50000000
`define CID_XTAL_HZ 3579545
`define CID_BAUD 1200
`define CID_OVERSAMPLE 16
`define CID_XTAL_DIV (`CID_XTAL_HZ / (`CID_BAUD * `CID_OVERSAMPLE))
`define CID_HALF_BIT (`CID_OVERSAMPLE / 2)
`define CID_WORD_BITS 8

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define CID_ADDR_CTRL 12'h000
`define CID_ADDR_STATUS 12'h004
`define CID_ADDR_DATA 12'h008
`define CID_ADDR_IRQ_STAT 12'h00C
`define CID_ADDR_IRQ_MASK 12'h010

// ctrl fields
`define CID_CTRL_MODE 0
`define CID_CTRL_SLEEP 1
`define CID_CTRL_DEMOD 2
`define CID_CTRL_W 3
`define CID_CTRL_RESET 3'h0

// irq status / mask fields
`define CID_IRQ_WORD 0
`define CID_IRQ_CARRIER 1
`define CID_IRQ_ALERT 2
`define CID_IRQ_EVENT 3
`define CID_IRQ_W 4
`define CID_IRQ_RESET 4'h0

// live status fields
`define CID_ST_CARRIER 0
`define CID_ST_EARLY 1
`define CID_ST_ALERT 2
`define CID_ST_EVENT 3
`define CID_ST_WORD 4
`define CID_ST_MODE 5
`define CID_ST_SLEEP 6
`define CID_ST_W 7

`endif

//--- rtl/cid_pkg.sv
package cid_pkg;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } rx_state_e;
   typedef logic [7:0] word_t;
endpackage

//--- rtl/sync2.sv
`timescale 1ns/10ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

//--- rtl/char_receiver.sv
`timescale 1ns/10ps
`include "cid_defs.svh"
module char_receiver
   import cid_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic enable,
   input wire logic rx_level,
   output logic bit_valid,
   output logic bit_value,
   output logic char_valid,
   output word_t char_data
);
   rx_state_e state_reg;
   logic [3:0] phase_reg;
   logic [2:0] idx_reg;
   word_t shift_reg;
   wire mid_point = tick && (phase_reg == 4'(`CID_HALF_BIT - 1));
   wire bit_end = tick && (phase_reg == 4'(`CID_OVERSAMPLE - 1));
   wire last_bit = (idx_reg == 3'(`CID_WORD_BITS - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= RX_IDLE;
         phase_reg <= 4'h0;
         idx_reg <= 3'h0;
         shift_reg <= 8'h00;
         bit_valid <= 1'b0;
         bit_value <= 1'b0;
         char_valid <= 1'b0;
         char_data <= 8'h00;
      end else begin
         bit_valid <= 1'b0;
         char_valid <= 1'b0;
         if (tick) begin
            phase_reg <= phase_reg + 4'h1;
         end
         if (!enable) begin
            state_reg <= RX_IDLE;
         end else begin
            case (state_reg)
               RX_IDLE: begin
                  phase_reg <= 4'h0;
                  if (!rx_level) begin
                     state_reg <= RX_START;
                  end
               end
               RX_START: begin
                  // restart phase at mid-bit so later samples land mid-cell
                  if (mid_point) begin
                     phase_reg <= 4'h0;
                     idx_reg <= 3'h0;
                     state_reg <= rx_level ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (bit_end) begin
                     shift_reg <= {rx_level, shift_reg[7:1]};
                     bit_valid <= 1'b1;
                     bit_value <= rx_level;
                     idx_reg <= idx_reg + 3'h1;
                     if (last_bit) begin
                        state_reg <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  if (bit_end) begin
                     // framing error drops the word
                     char_valid <= rx_level;
                     char_data <= shift_reg;
                     state_reg <= RX_IDLE;
                  end
               end
               default: state_reg <= RX_IDLE;
            endcase
         end
      end
   end
endmodule

//--- rtl/caller_id_serial_output.sv
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "cid_defs.svh"
module caller_id_serial_output
   import cid_pkg::*;
#(
   parameter int XTAL_DIV = `CID_XTAL_DIV
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic xtal_in,
   output logic xtal_out,
   input wire logic fsk_bit_in,
   input wire logic band_energy,
   input wire logic tone_low,
   input wire logic tone_high,
   input wire logic guard_time_node,
   input wire logic event_sense_in,
   input wire logic event_hold_node_in,
   output logic event_hold_node_out,
   output logic event_hold_node_oe_n,
   input wire logic interface_clock_in,
   output logic interface_clock_out,
   output logic interface_clock_oe_n,
   output logic serial_data,
   output logic word_ready_n,
   output logic carrier_present_n,
   output logic qualified_alert,
   output logic early_alert,
   output logic event_flag_n,
   output logic int_out,
   output logic int_oe_n,
   output logic irq
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [8:0] pins_s;
   sync2 #(
      .WIDTH(9)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({xtal_in, fsk_bit_in, band_energy, tone_low, tone_high,
                 guard_time_node, event_sense_in, !event_hold_node_in,
                 interface_clock_in}),
      .sync_out(pins_s)
   );
   wire xtal_s = pins_s[8];
   wire fsk_s = pins_s[7];
   wire energy_s = pins_s[6];
   wire tone_low_s = pins_s[5];
   wire tone_high_s = pins_s[4];
   wire guard_s = pins_s[3];
   wire sense_s = pins_s[2];
   wire hold_s = !pins_s[1]; // stored inverted so reset reads the idle high node
   wire host_clk_s = pins_s[0];

   // ------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------
   logic [`CID_CTRL_W-1:0] ctrl_reg;
   wire mode1 = ctrl_reg[`CID_CTRL_MODE];
   wire sleep_request = ctrl_reg[`CID_CTRL_SLEEP];
   wire demod_enable = ctrl_reg[`CID_CTRL_DEMOD];
   wire awake = !sleep_request;

   // ------------------------------------------------------------
   // crystal-referenced oversample tick
   // ------------------------------------------------------------
   // crystal edges rather than pclk set the bit rate, so baud accuracy
   // follows the crystal and not the bus clock
   logic xtal_prev_reg;
   logic [15:0] xtal_cnt_reg;
   logic os_tick;
   wire xtal_rise = xtal_s && !xtal_prev_reg;
   wire xtal_wrap = (xtal_cnt_reg == 16'(XTAL_DIV - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_prev_reg <= 1'b0;
         xtal_cnt_reg <= 16'h0000;
         os_tick <= 1'b0;
         xtal_out <= 1'b1;
      end else begin
         xtal_prev_reg <= xtal_s;
         xtal_out <= !xtal_s;
         os_tick <= 1'b0;
         if (!awake) begin
            xtal_cnt_reg <= 16'h0000;
         end else if (xtal_rise) begin
            xtal_cnt_reg <= xtal_wrap ? 16'h0000 : xtal_cnt_reg + 16'h0001;
            os_tick <= xtal_wrap;
         end
      end
   end

   // ------------------------------------------------------------
   // character recovery
   // ------------------------------------------------------------
   logic rx_bit_valid;
   logic rx_bit_value;
   logic rx_char_valid;
   word_t rx_char;
   wire rx_enable = demod_enable && awake;

   char_receiver u_rx (
      .pclk(pclk),
      .presetn(presetn),
      .tick(os_tick),
      .enable(rx_enable),
      .rx_level(fsk_s),
      .bit_valid(rx_bit_valid),
      .bit_value(rx_bit_value),
      .char_valid(rx_char_valid),
      .char_data(rx_char)
   );

   // ------------------------------------------------------------
   // mode 0: device-clocked stream
   // ------------------------------------------------------------
   logic [3:0] m0_clk_cnt_reg;
   logic [3:0] m0_bits_reg;
   logic [3:0] m0_dr_cnt_reg;
   wire m0_bit = !mode1 && rx_bit_valid;
   wire m0_clk_end = os_tick && (m0_clk_cnt_reg == 4'h1);
   wire m0_word_end = m0_clk_end && (m0_bits_reg == 4'(`CID_WORD_BITS));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m0_clk_cnt_reg <= 4'h0;
         m0_bits_reg <= 4'h0;
      end else if (mode1 || !awake) begin
         m0_clk_cnt_reg <= 4'h0;
         m0_bits_reg <= 4'h0;
      end else if (m0_bit) begin
         m0_clk_cnt_reg <= 4'(`CID_HALF_BIT);
         m0_bits_reg <= m0_bits_reg + 4'h1;
      end else if (m0_word_end) begin
         m0_clk_cnt_reg <= 4'h0;
         m0_bits_reg <= 4'h0;
      end else if (os_tick && m0_clk_cnt_reg != 4'h0) begin
         m0_clk_cnt_reg <= m0_clk_cnt_reg - 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m0_dr_cnt_reg <= 4'h0;
      end else if (mode1 || !awake || m0_bit) begin
         m0_dr_cnt_reg <= 4'h0;
      end else if (m0_word_end) begin
         m0_dr_cnt_reg <= 4'(`CID_HALF_BIT);
      end else if (os_tick && m0_dr_cnt_reg != 4'h0) begin
         m0_dr_cnt_reg <= m0_dr_cnt_reg - 4'h1;
      end
   end

   // ------------------------------------------------------------
   // mode 1: host-clocked word
   // ------------------------------------------------------------
   // a new word overwrites one the host has not finished; no overrun flag
   logic host_prev_reg;
   word_t m1_shift_reg;
   logic [3:0] m1_left_reg;
   wire host_rise = host_clk_s && !host_prev_reg;
   wire m1_load = mode1 && rx_char_valid;
   wire m1_step = mode1 && host_rise && (m1_left_reg != 4'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_prev_reg <= 1'b0;
         m1_shift_reg <= 8'h00;
         m1_left_reg <= 4'h0;
      end else begin
         host_prev_reg <= host_clk_s;
         if (!mode1 || !awake) begin
            m1_left_reg <= 4'h0;
         end else if (m1_load) begin
            m1_shift_reg <= rx_char;
            m1_left_reg <= 4'(`CID_WORD_BITS);
         end else if (m1_step) begin
            m1_shift_reg <= {1'b0, m1_shift_reg[7:1]};
            m1_left_reg <= m1_left_reg - 4'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // three-wire outputs
   // ------------------------------------------------------------
   wire data_next = !mode1 ? (m0_bit ? rx_bit_value : serial_data)
                    : m1_load ? rx_char[0]
                    : m1_step ? m1_shift_reg[1] : serial_data;
   wire word_ready_next = mode1 ? (m1_left_reg != 4'h0) : (m0_dr_cnt_reg != 4'h0);
   wire interface_clock_next = !mode1 && (m0_clk_cnt_reg != 4'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_data <= 1'b0;
         word_ready_n <= 1'b1;
         interface_clock_out <= 1'b0;
         interface_clock_oe_n <= 1'b1;
      end else begin
         serial_data <= data_next;
         word_ready_n <= !(word_ready_next && awake);
         interface_clock_out <= interface_clock_next;
         interface_clock_oe_n <= mode1;
      end
   end

   // ------------------------------------------------------------
   // carrier, alert and event flags
   // ------------------------------------------------------------
   // hold node is pulled low while sensing; flag stays low until the
   // external rc lets the node climb back over its threshold
   wire event_active = sense_s || !hold_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carrier_present_n <= 1'b1;
         early_alert <= 1'b0;
         qualified_alert <= 1'b0;
         event_flag_n <= 1'b1;
         event_hold_node_oe_n <= 1'b1;
      end else begin
         carrier_present_n <= !(energy_s && awake);
         early_alert <= tone_low_s && tone_high_s && awake;
         qualified_alert <= guard_s && awake;
         event_flag_n <= !event_active;
         event_hold_node_oe_n <= !sense_s;
      end
   end
   assign event_hold_node_out = 1'b0;

   // merged open-drain interrupt
   assign int_out = 1'b0;
   assign int_oe_n = !(!event_flag_n || !word_ready_n || qualified_alert);

   // ------------------------------------------------------------
   // event capture for software
   // ------------------------------------------------------------
   logic carrier_prev_reg;
   logic alert_prev_reg;
   logic event_prev_reg;
   wire [`CID_IRQ_W-1:0] irq_set = {
      event_prev_reg && !event_flag_n,
      qualified_alert && !alert_prev_reg,
      !carrier_present_n && carrier_prev_reg,
      rx_char_valid};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carrier_prev_reg <= 1'b1;
         alert_prev_reg <= 1'b0;
         event_prev_reg <= 1'b1;
      end else begin
         carrier_prev_reg <= carrier_present_n;
         alert_prev_reg <= qualified_alert;
         event_prev_reg <= event_flag_n;
      end
   end

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   logic [`CID_IRQ_W-1:0] irq_stat_reg;
   logic [`CID_IRQ_W-1:0] irq_mask_reg;
   word_t data_reg;
   wire setup = psel && !penable;
   wire access = psel && penable;
   wire hit_ctrl = (paddr == `CID_ADDR_CTRL);
   wire hit_status = (paddr == `CID_ADDR_STATUS);
   wire hit_data = (paddr == `CID_ADDR_DATA);
   wire hit_istat = (paddr == `CID_ADDR_IRQ_STAT);
   wire hit_imask = (paddr == `CID_ADDR_IRQ_MASK);
   wire hit_any = hit_ctrl || hit_status || hit_data || hit_istat || hit_imask;
   wire wr_ctrl = access && pwrite && hit_ctrl;
   wire wr_imask = access && pwrite && hit_imask;
   wire rd_istat = access && !pwrite && hit_istat;
   wire [`CID_ST_W-1:0] live_status = {
      sleep_request, mode1, !word_ready_n, !event_flag_n,
      qualified_alert, early_alert, !carrier_present_n};
   wire [31:0] rd_mux =
      hit_ctrl ? {29'h0, ctrl_reg} :
      hit_status ? {25'h0, live_status} :
      hit_data ? {24'h0, data_reg} :
      hit_istat ? {28'h0, irq_stat_reg} :
      hit_imask ? {28'h0, irq_mask_reg} : 32'h0;
   // clear only bits software actually saw; a set in the same cycle wins
   wire [`CID_IRQ_W-1:0] irq_clr = rd_istat ? prdata[`CID_IRQ_W-1:0] : 4'h0;

   assign pready = 1'b1;
   assign pslverr = access && !hit_any;
   assign irq = |(irq_stat_reg & irq_mask_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (setup && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `CID_CTRL_RESET;
         irq_mask_reg <= `CID_IRQ_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= pwdata[`CID_CTRL_W-1:0];
         end
         if (wr_imask) begin
            irq_mask_reg <= pwdata[`CID_IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= `CID_IRQ_RESET;
         data_reg <= 8'h00;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
         if (rx_char_valid) begin
            data_reg <= rx_char;
         end
      end
   end
endmodule

//--- verif/caller_id_serial_output_assertions.sv
`timescale 1ns/10ps
module caller_id_serial_output_assertions #(
   parameter int XTAL_DIV = 186
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic band_energy,
   input wire logic tone_low,
   input wire logic tone_high,
   input wire logic guard_time_node,
   input wire logic event_sense_in,
   input wire logic event_hold_node_in,
   input wire logic event_hold_node_oe_n,
   input wire logic interface_clock_out,
   input wire logic interface_clock_oe_n,
   input wire logic word_ready_n,
   input wire logic carrier_present_n,
   input wire logic qualified_alert,
   input wire logic early_alert,
   input wire logic event_flag_n,
   input wire logic int_oe_n
);
   // ---------------------------------
   // control mirror, taken from apb writes
   // ---------------------------------
   logic mode_reg;
   logic sleep_reg;
   wire ctrl_wr = psel && penable && pwrite && (paddr == 12'h000);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= 1'b0;
         sleep_reg <= 1'b0;
      end else if (ctrl_wr) begin
         mode_reg <= pwdata[0];
         sleep_reg <= pwdata[1];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------
   // properties, 3-cycle input latency
   // ---------------------------------
   property p_carrier;
      (!sleep_reg && $stable(band_energy))[*4] |-> carrier_present_n == !band_energy;
   endproperty
   a_carrier: assert property (p_carrier) else $error("carrier flag wrong");
   property p_early;
      (!sleep_reg && $stable(tone_low && tone_high))[*4]
         |-> early_alert == (tone_low && tone_high);
   endproperty
   a_early: assert property (p_early) else $error("early alert wrong");
   property p_qual;
      (!sleep_reg && $stable(guard_time_node))[*4] |-> qualified_alert == guard_time_node;
   endproperty
   a_qual: assert property (p_qual) else $error("qualified alert wrong");
   property p_event;
      ($stable(event_sense_in) && $stable(event_hold_node_in))[*4]
         |-> event_flag_n == !(event_sense_in || !event_hold_node_in);
   endproperty
   a_event: assert property (p_event) else $error("event flag wrong");
   property p_hold;
      $stable(event_sense_in)[*4] |-> event_hold_node_oe_n == !event_sense_in;
   endproperty
   a_hold: assert property (p_hold) else $error("hold node drive wrong");
   property p_int;
      int_oe_n == !(!event_flag_n || !word_ready_n || qualified_alert);
   endproperty
   a_int: assert property (p_int) else $error("interrupt pin wrong");
   property p_dir;
      $stable(mode_reg)[*3] |-> interface_clock_oe_n == mode_reg;
   endproperty
   a_dir: assert property (p_dir) else $error("clock direction wrong");
   property p_sleep;
      sleep_reg[*4] |-> word_ready_n && carrier_present_n && !qualified_alert && !early_alert;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not quiet");
   property p_ready0;
      (!mode_reg && !word_ready_n) |-> !interface_clock_out;
   endproperty
   a_ready0: assert property (p_ready0) else $error("ready during clock");
endmodule

//--- verif/host_model.sv
`timescale 1ns/10ps
module host_model (
   input wire logic active,
   input wire logic slow,
   input wire logic word_ready_n,
   input wire logic serial_data,
   output logic host_clock,
   output logic [7:0] host_word,
   output int host_count
);
   // clock stands low between words; data read just before each rise
   initial begin
      host_clock = 1'b0;
      host_word = 8'h00;
      host_count = 0;
      forever begin
         wait (active && word_ready_n === 1'b0);
         #(slow ? 4000 : 100);
         host_word[0] = serial_data;
         for (int i = 1; i <= 8; i++) begin
            host_clock = 1'b1;
            #80;
            host_clock = 1'b0;
            #80;
            if (i < 8) host_word[i] = serial_data;
         end
         host_count++;
         wait (word_ready_n === 1'b1);
      end
   end
endmodule

//--- verif/caller_id_serial_output_test.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module caller_id_serial_output_test;
   import cid_pkg::*;
   localparam int BIT_CYC = 160;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic xtal_in, fsk_bit_in, band_energy, tone_low, tone_high, guard_time_node;
   logic event_sense_in, rc_level, event_hold_node_oe_n, interface_clock_out;
   logic interface_clock_oe_n, serial_data, word_ready_n, carrier_present_n;
   logic qualified_alert, early_alert, event_flag_n, int_oe_n, irq;
   logic host_clock, host_on, host_slow;
   logic [7:0] host_word, rx0;
   int host_count, n0, wr_cnt, fails, checked, cyc;
   // open-drain rc node and two-way clock resolved here
   wire hold_node = event_hold_node_oe_n ? rc_level : 1'b0;
   wire interface_clock = interface_clock_oe_n ? host_clock : interface_clock_out;
   caller_id_serial_output #(.XTAL_DIV(2)) dut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .xtal_in(xtal_in),
      .xtal_out(), .fsk_bit_in(fsk_bit_in), .band_energy(band_energy),
      .tone_low(tone_low), .tone_high(tone_high), .guard_time_node(guard_time_node),
      .event_sense_in(event_sense_in), .event_hold_node_in(hold_node),
      .event_hold_node_out(), .event_hold_node_oe_n(event_hold_node_oe_n),
      .interface_clock_in(interface_clock), .interface_clock_out(interface_clock_out),
      .interface_clock_oe_n(interface_clock_oe_n), .serial_data(serial_data),
      .word_ready_n(word_ready_n), .carrier_present_n(carrier_present_n),
      .qualified_alert(qualified_alert), .early_alert(early_alert),
      .event_flag_n(event_flag_n), .int_out(), .int_oe_n(int_oe_n), .irq(irq));
   host_model host (.active(host_on), .slow(host_slow), .word_ready_n(word_ready_n),
      .serial_data(serial_data), .host_clock(host_clock), .host_word(host_word),
      .host_count(host_count));
   // ---------------------------------
   // clocks, watchers, timeout
   // ---------------------------------
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      xtal_in = 1'b0;
      forever #50 xtal_in = ~xtal_in;
   end
   always @(negedge interface_clock_out) if (!interface_clock_oe_n) begin
      rx0 = {serial_data, rx0[7:1]};
      n0++;
   end
   always @(negedge word_ready_n) wr_cnt++;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         complete_run();
      end
   end
   task complete_run;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ---------------------------------
   // bus and line tasks
   // ---------------------------------
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task settle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task send_byte(input word_t b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         fsk_bit_in <= f[i];
         settle(BIT_CYC);
      end
   endtask
   // ---------------------------------
   // scenarios
   // ---------------------------------
   task t_reset;
      `CHK("word_ready_n", 1'b1, word_ready_n)
      `CHK("event_flag_n", 1'b1, event_flag_n)
      `CHK("int_oe_n", 1'b1, int_oe_n)
      `CHK("clock_oe_n", 1'b0, interface_clock_oe_n)
      apb(12'h000, 1'b0, 32'h0);
      `CHK("ctrl", 32'h0, rd)
      apb(12'h014, 1'b0, 32'h0);
      `CHK("unmapped err", 1'b1, slv)
      `CHK("unmapped data", 32'h0, rd)
   endtask
   task t_mode0;
      int n, w;
      apb(12'h010, 1'b1, 32'h1);
      apb(12'h000, 1'b1, 32'h4);
      n = n0;
      w = wr_cnt;
      send_byte(8'hB4);
      for (int i = 0; i < 400 && wr_cnt == w; i++) @(posedge pclk);
      `CHK("mode0 bits", 8, n0 - n)
      `CHK("mode0 word", 8'hB4, rx0)
      `CHK("ready pulses", 1, wr_cnt - w)
      apb(12'h008, 1'b0, 32'h0);
      `CHK("data reg", 32'hB4, rd)
      `CHK("irq", 1'b1, irq)
      apb(12'h00C, 1'b0, 32'h0);
      `CHK("irq stat", 32'h1, rd)
      settle(1);
      `CHK("irq cleared", 1'b0, irq)
      apb(12'h00C, 1'b0, 32'h0);
      `CHK("irq stat clr", 32'h0, rd)
   endtask
   task t_mode1;
      int h;
      apb(12'h000, 1'b1, 32'h5);
      host_on <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         h = host_count;
         host_slow <= k[0];
         send_byte(k ? 8'hC3 : 8'h3C);
         if (k) `CHK("ready held", 1'b0, word_ready_n)
         for (int i = 0; i < 2000 && host_count == h; i++) @(posedge pclk);
         `CHK("host word", k ? 8'hC3 : 8'h3C, host_word)
         `CHK("host count", 1, host_count - h)
         `CHK("ready done", 1'b1, word_ready_n)
         `CHK("clock oe_n", 1'b1, interface_clock_oe_n)
      end
      host_on <= 1'b0;
      host_slow <= 1'b0;
   endtask
   task t_gate;
      int n, w;
      n = n0;
      w = wr_cnt;
      apb(12'h000, 1'b1, 32'h0);
      send_byte(8'h55);
      settle(200);
      `CHK("demod off", 0, wr_cnt - w)
      apb(12'h000, 1'b1, 32'h6);
      send_byte(8'h55);
      settle(200);
      `CHK("sleep bits", 0, n0 - n)
      band_energy <= 1'b1;
      event_sense_in <= 1'b1;
      settle(8);
      `CHK("sleep carrier", 1'b1, carrier_present_n)
      `CHK("sleep event", 1'b0, event_flag_n)
      band_energy <= 1'b0;
      event_sense_in <= 1'b0;
      settle(8);
   endtask
   task t_signals;
      apb(12'h000, 1'b1, 32'h4);
      apb(12'h010, 1'b1, 32'h0);
      apb(12'h00C, 1'b0, 32'h0);
      band_energy <= 1'b1;
      tone_low <= 1'b1;
      tone_high <= 1'b1;
      settle(6);
      `CHK("carrier", 1'b0, carrier_present_n)
      `CHK("early", 1'b1, early_alert)
      `CHK("qual idle", 1'b0, qualified_alert)
      apb(12'h004, 1'b0, 32'h0);
      `CHK("status", 32'h3, rd)
      tone_high <= 1'b0;
      guard_time_node <= 1'b1;
      settle(6);
      `CHK("early off", 1'b0, early_alert)
      `CHK("qual", 1'b1, qualified_alert)
      `CHK("int alert", 1'b0, int_oe_n)
      `CHK("irq masked", 1'b0, irq)
      guard_time_node <= 1'b0;
      band_energy <= 1'b0;
      tone_low <= 1'b0;
      rc_level <= 1'b0;
      event_sense_in <= 1'b1;
      settle(6);
      `CHK("qual off", 1'b0, qualified_alert)
      `CHK("event low", 1'b0, event_flag_n)
      `CHK("hold drive", 1'b0, event_hold_node_oe_n)
      event_sense_in <= 1'b0;
      settle(20);
      `CHK("event held", 1'b0, event_flag_n)
      rc_level <= 1'b1;
      settle(6);
      `CHK("event free", 1'b1, event_flag_n)
      `CHK("int free", 1'b1, int_oe_n)
      apb(12'h00C, 1'b0, 32'h0);
      `CHK("irq events", 32'hE, rd)
   endtask
   initial begin
      {presetn, psel, penable, pwrite, band_energy, tone_low, tone_high} = '0;
      {guard_time_node, event_sense_in, host_on, host_slow} = '0;
      paddr = 12'h000;
      pwdata = 32'h0;
      fsk_bit_in = 1'b1;
      rc_level = 1'b1;
      settle(12);
      presetn <= 1'b1;
      settle(4);
      t_reset();
      t_mode0();
      t_mode1();
      t_gate();
      t_signals();
      complete_run();
   end
endmodule
bind caller_id_serial_output caller_id_serial_output_assertions #(.XTAL_DIV(XTAL_DIV)) chk (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .band_energy(band_energy), .tone_low(tone_low),
   .tone_high(tone_high), .guard_time_node(guard_time_node),
   .event_sense_in(event_sense_in), .event_hold_node_in(event_hold_node_in),
   .event_hold_node_oe_n(event_hold_node_oe_n), .interface_clock_out(interface_clock_out),
   .interface_clock_oe_n(interface_clock_oe_n), .word_ready_n(word_ready_n),
   .carrier_present_n(carrier_present_n), .qualified_alert(qualified_alert),
   .early_alert(early_alert), .event_flag_n(event_flag_n), .int_oe_n(int_oe_n));
